// ===== inc/aip_pkg.sv
// constants and types shared by both ends of the control port
// assumes a 100 MHz ref_clk on the host and on the device's user side
`default_nettype none
package aip_pkg;
  localparam int unsigned REF_CLK_NS     = 10;
  localparam int unsigned SCL_RATE_KBPS  = 100;
  localparam int unsigned SCL_QUARTER_NS = 1_000_000 / (SCL_RATE_KBPS * 4);
  localparam logic [8:0]  QUARTER_CYC    =
    9'((SCL_QUARTER_NS + REF_CLK_NS - 1) / REF_CLK_NS);

  localparam logic [5:0] ADDR_BASE  = 6'h1A;
  localparam logic [7:0] SUB_VOLUME = 8'h04;
  localparam logic [7:0] SUB_TREBLE = 8'h05;
  localparam logic [7:0] SUB_BASS   = 8'h06;
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic [2:0] FIFO_DEPTH = 3'h7;
  localparam logic [7:0] EMPTY_BYTE = 8'h00;

  localparam int unsigned WAIT_W     = 25;
  localparam int unsigned CYC_PER_MS = 1_000_000 / REF_CLK_NS;
  localparam int unsigned VOL_32_MS  = 62;
  localparam int unsigned VOL_44_MS  = 49;
  localparam int unsigned VOL_48_MS  = 41;
  localparam int unsigned TONE_32_MS = 231;
  localparam int unsigned TONE_44_MS = 167;
  localparam int unsigned TONE_48_MS = 153;
  localparam int unsigned VOL_32_CYC  = VOL_32_MS * CYC_PER_MS;
  localparam int unsigned VOL_44_CYC  = VOL_44_MS * CYC_PER_MS;
  localparam int unsigned VOL_48_CYC  = VOL_48_MS * CYC_PER_MS;
  localparam int unsigned TONE_32_CYC = TONE_32_MS * CYC_PER_MS;
  localparam int unsigned TONE_44_CYC = TONE_44_MS * CYC_PER_MS;
  localparam int unsigned TONE_48_CYC = TONE_48_MS * CYC_PER_MS;

  typedef enum logic [1:0] {
    FS_32K = 2'h0,
    FS_44K = 2'h1,
    FS_48K = 2'h2
  } aip_fs_t;

  typedef enum logic [2:0] {
    DS_IDLE  = 3'h0,
    DS_RX    = 3'h1,
    DS_RXACK = 3'h2,
    DS_HOLD  = 3'h3,
    DS_TX    = 3'h4,
    DS_TXACK = 3'h5
  } aip_dev_state_t;

  typedef enum logic [1:0] {
    HS_IDLE  = 2'h0,
    HS_START = 2'h1,
    HS_BIT   = 2'h2,
    HS_STOP  = 2'h3
  } aip_host_state_t;
endpackage : aip_pkg
`default_nettype wire

// ===== inc/aip_bus_if.sv
// two-wire bus between the port and its master
// assumes a pull-up: a line is low only while some end enables a low drive
`default_nettype none
interface aip_bus_if;
  logic scl_dev_o;
  logic scl_dev_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic scl_host_o;
  logic scl_host_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic scl;
  logic sda;

  assign scl = ~((scl_dev_oe & ~scl_dev_o) | (scl_host_oe & ~scl_host_o));
  assign sda = ~((sda_dev_oe & ~sda_dev_o) | (sda_host_oe & ~sda_host_o));

  modport dev (
    input  scl, sda,
    output scl_dev_o, scl_dev_oe, sda_dev_o, sda_dev_oe
  );
  modport host (
    input  scl, sda,
    output scl_host_o, scl_host_oe, sda_host_o, sda_host_oe
  );
endinterface : aip_bus_if
`default_nettype wire

// ===== logic/aip_sync.sv
// two-flop synchroniser for levels entering a clock domain
// assumes each bit is a level or a slow toggle
`default_nettype none
module aip_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : aip_sync
`default_nettype wire

// ===== logic/aip_dev_end.sv
// device end: two-wire slave with readback store and wait states
// assumes link_clk is the device clock, far faster than the bus rate
`default_nettype none
// How it works
// - sda fall / rise with scl high: start / stop
// - data moves only while scl is low
// - master opens with address and direction bit
// - device pulls sda low for whole ack clock
// - receiver acks every byte except the last byte read back
// - any byte count between start and stop
// - address is 0110 10 plus select pin
// - answers 68h/69h or 6Ah/6Bh by pin
// - first write byte is the subaddress
// - master sends full byte count per subaddress
// - last seven bytes kept, oldest read first
// - master ack pops next byte; stop ends
// - master ends readback with stop, not ack
// - volume or tone change delays next write command
// - volume wait 62/49/41 ms by rate
// - tone wait 231/167/153 ms by rate
// - short waits possible in long series
// - waits up to 15 ms at 32 kHz
// - compression and eq loads may wait
// - master stops sending during wait
// - bus runs at most 100 kbps
// - reset releases scl and sda
module aip_dev_end #(
  parameter int unsigned VOL_WAIT_32  = aip_pkg::VOL_32_CYC,
  parameter int unsigned VOL_WAIT_44  = aip_pkg::VOL_44_CYC,
  parameter int unsigned VOL_WAIT_48  = aip_pkg::VOL_48_CYC,
  parameter int unsigned TONE_WAIT_32 = aip_pkg::TONE_32_CYC,
  parameter int unsigned TONE_WAIT_44 = aip_pkg::TONE_44_CYC,
  parameter int unsigned TONE_WAIT_48 = aip_pkg::TONE_48_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       link_clk,
  input  wire logic       nrst,
  input  wire logic       addr_select_pin,
  input  wire logic [1:0] fs_sel,
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  output logic            wait_busy,
  aip_bus_if.dev          bus
);
  localparam int unsigned WW = aip_pkg::WAIT_W;

  aip_pkg::aip_dev_state_t state_reg;
  logic [2:0]  pins_m;
  logic        scl_m, sda_m, sel_m, scl_q, sda_q;
  logic        scl_rise, scl_fall, start_c, stop_c;
  logic [3:0]  bit_cnt_reg;
  logic [1:0]  byte_idx_reg;
  logic [7:0]  shift_reg, tx_reg, sub_reg, rx_hold_reg;
  logic        is_read_reg, sda_oe_reg, scl_oe_reg, addr_hit;
  logic        push_c, pop_c, busy_s;
  logic [7:0]  fifo_mem [7];
  logic [2:0]  wr_ptr_reg, count_reg;
  logic [7:0]  fifo_head;
  logic        wait_tgl_reg, wait_tone_reg, rx_tgl_reg;
  logic [1:0]  tgl_m;
  logic        wait_tgl_q, rx_tgl_q;
  logic [WW-1:0] wait_cnt_reg;

  function automatic logic [2:0] wrap7(input logic [3:0] v);
    logic [3:0] r;
    r = (v >= {1'b0, aip_pkg::FIFO_DEPTH}) ?
        4'(v - {1'b0, aip_pkg::FIFO_DEPTH}) : v;
    return r[2:0];
  endfunction : wrap7

  function automatic logic [WW-1:0] wait_len(input logic [1:0] fs,
                                             input logic       tone);
    logic [WW-1:0] r;
    unique case (fs)
      aip_pkg::FS_32K: r = tone ? WW'(TONE_WAIT_32) : WW'(VOL_WAIT_32);
      aip_pkg::FS_44K: r = tone ? WW'(TONE_WAIT_44) : WW'(VOL_WAIT_44);
      default:         r = tone ? WW'(TONE_WAIT_48) : WW'(VOL_WAIT_48);
    endcase
    return r;
  endfunction : wait_len

  // bus pins and strap into the device clock
  aip_sync #(.W(3)) u_pin_sync (
    .clk  (link_clk),
    .nrst (nrst),
    .d    ({bus.scl, bus.sda, addr_select_pin}),
    .q    (pins_m)
  );
  assign scl_m = pins_m[2];
  assign sda_m = pins_m[1];
  assign sel_m = pins_m[0];

  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_m;
      sda_q <= sda_m;
    end
  end

  assign scl_rise = scl_m & ~scl_q;
  assign scl_fall = ~scl_m & scl_q;
  assign start_c  = scl_m & scl_q & sda_q & ~sda_m;
  assign stop_c   = scl_m & scl_q & ~sda_q & sda_m;
  assign addr_hit = shift_reg[7:1] == {aip_pkg::ADDR_BASE, sel_m};
  assign push_c   = state_reg == aip_pkg::DS_RX && scl_fall
                    && bit_cnt_reg == aip_pkg::BYTE_BITS
                    && byte_idx_reg != 2'h0;
  assign pop_c    = scl_fall && ((state_reg == aip_pkg::DS_RXACK
                    && is_read_reg) || state_reg == aip_pkg::DS_TXACK);

  // open-drain: only a low is ever driven
  assign bus.scl_dev_o  = 1'b0;
  assign bus.sda_dev_o  = 1'b0;
  assign bus.scl_dev_oe = scl_oe_reg;
  assign bus.sda_dev_oe = sda_oe_reg;

  // byte engine
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg    <= aip_pkg::DS_IDLE;
      bit_cnt_reg  <= 4'h0;
      byte_idx_reg <= 2'h0;
      shift_reg    <= 8'h00;
      tx_reg       <= 8'h00;
      sub_reg      <= 8'h00;
      is_read_reg  <= 1'b0;
      sda_oe_reg   <= 1'b0;
      scl_oe_reg   <= 1'b0;
    end else if (start_c) begin
      state_reg    <= aip_pkg::DS_RX;
      bit_cnt_reg  <= 4'h0;
      byte_idx_reg <= 2'h0;
      sda_oe_reg   <= 1'b0;
      scl_oe_reg   <= 1'b0;
    end else if (stop_c) begin
      state_reg  <= aip_pkg::DS_IDLE;
      sda_oe_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        aip_pkg::DS_IDLE: begin
        end
        aip_pkg::DS_RX: begin
          if (scl_rise) begin
            shift_reg   <= {shift_reg[6:0], sda_m};
            bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
          end else if (scl_fall && bit_cnt_reg == aip_pkg::BYTE_BITS) begin
            bit_cnt_reg <= 4'h0;
            if (byte_idx_reg == 2'h0 && !addr_hit) begin
              state_reg <= aip_pkg::DS_IDLE;
            end else begin
              sda_oe_reg <= 1'b1;
              state_reg  <= aip_pkg::DS_RXACK;
              if (byte_idx_reg == 2'h0) begin
                is_read_reg <= shift_reg[0];
              end
              if (byte_idx_reg == 2'h1) begin
                sub_reg <= shift_reg;
              end
            end
          end
        end
        aip_pkg::DS_RXACK: begin
          if (scl_fall) begin
            sda_oe_reg <= 1'b0;
            if (byte_idx_reg != 2'h3) begin
              byte_idx_reg <= 2'(byte_idx_reg + 2'h1);
            end
            if (is_read_reg) begin
              tx_reg     <= fifo_head;
              sda_oe_reg <= ~fifo_head[7];
              state_reg  <= aip_pkg::DS_TX;
            end else if (byte_idx_reg == 2'h2 && busy_s) begin
              scl_oe_reg <= 1'b1;
              state_reg  <= aip_pkg::DS_HOLD;
            end else begin
              state_reg <= aip_pkg::DS_RX;
            end
          end
        end
        aip_pkg::DS_HOLD: begin
          if (!busy_s) begin
            scl_oe_reg <= 1'b0;
            state_reg  <= aip_pkg::DS_RX;
          end
        end
        aip_pkg::DS_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg == 4'h7) begin
              sda_oe_reg  <= 1'b0;
              bit_cnt_reg <= 4'h0;
              state_reg   <= aip_pkg::DS_TXACK;
            end else begin
              tx_reg      <= {tx_reg[6:0], 1'b0};
              sda_oe_reg  <= ~tx_reg[6];
              bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
            end
          end
        end
        aip_pkg::DS_TXACK: begin
          if (scl_rise && sda_m) begin
            state_reg <= aip_pkg::DS_IDLE;
          end else if (scl_fall) begin
            tx_reg     <= fifo_head;
            sda_oe_reg <= ~fifo_head[7];
            state_reg  <= aip_pkg::DS_TX;
          end
        end
        default: begin
          state_reg <= aip_pkg::DS_IDLE;
        end
      endcase
    end
  end

  // readback store: newest overwrites oldest when full
  assign fifo_head = (count_reg == 3'h0) ? aip_pkg::EMPTY_BYTE :
    fifo_mem[wrap7(4'({1'b0, wr_ptr_reg} + 4'h7 - {1'b0, count_reg}))];

  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_reg <= 3'h0;
      count_reg  <= 3'h0;
      for (int i = 0; i < 7; i++) begin
        fifo_mem[i] <= 8'h00;
      end
    end else if (push_c) begin
      fifo_mem[wr_ptr_reg] <= shift_reg;
      wr_ptr_reg <= wrap7(4'({1'b0, wr_ptr_reg} + 4'h1));
      if (count_reg != aip_pkg::FIFO_DEPTH) begin
        count_reg <= 3'(count_reg + 3'h1);
      end
    end else if (pop_c && count_reg != 3'h0) begin
      count_reg <= 3'(count_reg - 3'h1);
    end
  end

  // events toward the user domain
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      wait_tgl_reg  <= 1'b0;
      wait_tone_reg <= 1'b0;
      rx_tgl_reg    <= 1'b0;
      rx_hold_reg   <= 8'h00;
    end else begin
      if (push_c) begin
        rx_tgl_reg  <= ~rx_tgl_reg;
        rx_hold_reg <= shift_reg;
      end
      if (stop_c && !is_read_reg && byte_idx_reg == 2'h3 &&
          (sub_reg == aip_pkg::SUB_VOLUME ||
           sub_reg == aip_pkg::SUB_TREBLE ||
           sub_reg == aip_pkg::SUB_BASS)) begin
        wait_tgl_reg  <= ~wait_tgl_reg;
        wait_tone_reg <= sub_reg != aip_pkg::SUB_VOLUME;
      end
    end
  end

  aip_sync #(.W(2)) u_evt_sync (
    .clk  (ref_clk),
    .nrst (nrst),
    .d    ({wait_tgl_reg, rx_tgl_reg}),
    .q    (tgl_m)
  );

  // interpolation timer and received-byte capture
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wait_tgl_q   <= 1'b0;
      rx_tgl_q     <= 1'b0;
      wait_cnt_reg <= '0;
      wait_busy    <= 1'b0;
      rx_data      <= 8'h00;
      rx_valid     <= 1'b0;
    end else begin
      wait_tgl_q <= tgl_m[1];
      rx_tgl_q   <= tgl_m[0];
      rx_valid   <= tgl_m[0] ^ rx_tgl_q;
      if (tgl_m[0] ^ rx_tgl_q) begin
        rx_data <= rx_hold_reg;
      end
      if (tgl_m[1] ^ wait_tgl_q) begin
        wait_cnt_reg <= wait_len(fs_sel, wait_tone_reg);
        wait_busy    <= 1'b1;
      end else if (wait_cnt_reg != '0) begin
        wait_cnt_reg <= WW'(wait_cnt_reg - 1'b1);
        wait_busy    <= wait_cnt_reg != WW'(1);
      end
    end
  end

  aip_sync #(.W(1)) u_busy_sync (
    .clk  (link_clk),
    .nrst (nrst),
    .d    (wait_busy),
    .q    (busy_s)
  );
endmodule : aip_dev_end
`default_nettype wire

// ===== logic/aip_host_end.sv
// host end: two-wire master that writes, reads back and honours waits
// assumes ref_clk at 100 MHz; scl is divided from it
`default_nettype none
module aip_host_end (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       req_valid,
  input  wire logic       req_read,
  input  wire logic       req_sel,
  input  wire logic [3:0] req_len,
  input  wire logic [7:0] wr_data,
  output logic            req_ready,
  output logic            wr_take,
  output logic      [7:0] rd_data,
  output logic            rd_valid,
  output logic            done,
  output logic            nack,
  aip_bus_if.host         bus
);
  aip_pkg::aip_host_state_t state_reg;
  logic [1:0] pins_m, phase_reg;
  logic [8:0] q_cnt_reg, sh_reg, rx_reg;
  logic [3:0] bit_reg, byte_reg, len_reg;
  logic       rd_reg, scl_oe_reg, sda_oe_reg, tick, hold_q, rd_phase;

  aip_sync #(.W(2)) u_pin_sync (
    .clk  (ref_clk),
    .nrst (nrst),
    .d    ({bus.scl, bus.sda}),
    .q    (pins_m)
  );

  assign bus.scl_host_o  = 1'b0;
  assign bus.sda_host_o  = 1'b0;
  assign bus.scl_host_oe = scl_oe_reg;
  assign bus.sda_host_oe = sda_oe_reg;
  assign req_ready = state_reg == aip_pkg::HS_IDLE;
  assign tick      = q_cnt_reg == 9'(aip_pkg::QUARTER_CYC - 9'h1);
  // released scl still low: the device is stretching
  assign hold_q    = state_reg != aip_pkg::HS_IDLE && phase_reg == 2'h2
                     && !pins_m[1];
  assign rd_phase  = rd_reg && byte_reg != 4'h0;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      q_cnt_reg <= 9'h000;
    end else if (state_reg == aip_pkg::HS_IDLE || hold_q || tick) begin
      q_cnt_reg <= 9'h000;
    end else begin
      q_cnt_reg <= 9'(q_cnt_reg + 9'h001);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg  <= aip_pkg::HS_IDLE;
      phase_reg  <= 2'h0;
      sh_reg     <= 9'h1FF;
      rx_reg     <= 9'h000;
      bit_reg    <= 4'h0;
      byte_reg   <= 4'h0;
      len_reg    <= 4'h0;
      rd_reg     <= 1'b0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      rd_data    <= 8'h00;
      wr_take    <= 1'b0;
      rd_valid   <= 1'b0;
      done       <= 1'b0;
      nack       <= 1'b0;
    end else begin
      wr_take  <= 1'b0;
      rd_valid <= 1'b0;
      done     <= 1'b0;
      nack     <= 1'b0;
      unique case (state_reg)
        aip_pkg::HS_IDLE: begin
          if (req_valid) begin
            rd_reg    <= req_read;
            len_reg   <= req_len;
            byte_reg  <= 4'h0;
            bit_reg   <= 4'h0;
            phase_reg <= 2'h0;
            sh_reg    <= {aip_pkg::ADDR_BASE, req_sel, req_read, 1'b1};
            state_reg <= aip_pkg::HS_START;
          end
        end
        aip_pkg::HS_START: begin
          if (tick) begin
            if (phase_reg == 2'h0) begin
              sda_oe_reg <= 1'b1;
              phase_reg  <= 2'h1;
            end else begin
              scl_oe_reg <= 1'b1;
              phase_reg  <= 2'h0;
              state_reg  <= aip_pkg::HS_BIT;
            end
          end
        end
        aip_pkg::HS_BIT: begin
          if (tick) begin
            phase_reg <= 2'(phase_reg + 2'h1);
            unique case (phase_reg)
              2'h0: sda_oe_reg <= ~sh_reg[8];
              2'h1: scl_oe_reg <= 1'b0;
              2'h2: rx_reg <= {rx_reg[7:0], pins_m[0]};
              2'h3: begin
                scl_oe_reg <= 1'b1;
                if (bit_reg != aip_pkg::BYTE_BITS) begin
                  sh_reg  <= {sh_reg[7:0], 1'b0};
                  bit_reg <= 4'(bit_reg + 4'h1);
                end else begin
                  bit_reg <= 4'h0;
                  if (rd_phase) begin
                    rd_data  <= rx_reg[8:1];
                    rd_valid <= 1'b1;
                  end
                  if (!rd_phase && rx_reg[0]) begin
                    nack      <= 1'b1;
                    state_reg <= aip_pkg::HS_STOP;
                  end else if (byte_reg == len_reg) begin
                    state_reg <= aip_pkg::HS_STOP;
                  end else begin
                    byte_reg <= 4'(byte_reg + 4'h1);
                    if (rd_reg) begin
                      // last byte read answered by stop, not ack
                      sh_reg <= {8'hFF,
                        4'(byte_reg + 4'h1) == len_reg};
                    end else begin
                      sh_reg  <= {wr_data, 1'b1};
                      wr_take <= 1'b1;
                    end
                  end
                end
              end
            endcase
          end
        end
        aip_pkg::HS_STOP: begin
          if (tick) begin
            phase_reg <= 2'(phase_reg + 2'h1);
            unique case (phase_reg)
              2'h0: sda_oe_reg <= 1'b1;
              2'h1: scl_oe_reg <= 1'b0;
              2'h2: sda_oe_reg <= 1'b0;
              2'h3: begin
                done      <= 1'b1;
                state_reg <= aip_pkg::HS_IDLE;
              end
            endcase
          end
        end
      endcase
    end
  end
endmodule : aip_host_end
`default_nettype wire

// ===== verification/aip_bus_properties.sv
// assertions on the bus joining host end and device end
// assumes the bench hands in the interface signals and both clocks
`default_nettype none
module aip_bus_properties (
  input wire logic ref_clk,
  input wire logic link_clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_dev_oe,
  input wire logic sda_dev_oe,
  input wire logic scl_host_oe,
  input wire logic sda_host_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [10:0] gap_reg;

  // cycles since last scl rise; saturated means none seen since reset or for 2047 cycles
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      gap_reg <= 11'h7FF;
    end else if ($rose(scl)) begin
      gap_reg <= 11'h000;
    end else if (gap_reg != 11'h7FF) begin
      gap_reg <= gap_reg + 11'h001;
    end
  end

  sequence start_s;
    scl && $fell(sda);
  endsequence
  sequence stop_s;
    scl && $rose(sda);
  endsequence

  start_owner_a: assert property (@(posedge ref_clk)
    disable iff (!nrst) start_s |-> sda_host_oe && !scl_host_oe)
    else $error("start not from host");
  stop_owner_a: assert property (@(posedge ref_clk)
    disable iff (!nrst) stop_s |-> $past(sda_host_oe) && !sda_dev_oe)
    else $error("stop not from host");
  scl_period_a: assert property (@(posedge ref_clk)
    disable iff (!nrst) $rose(scl) |-> gap_reg >= 11'h3E7)
    else $error("scl period too short");
  host_low_a: assert property (@(posedge ref_clk)
    disable iff (!nrst) $rose(scl_host_oe) |-> scl_host_oe [*8])
    else $error("host scl low too short");
  dev_drive_a: assert property (@(posedge link_clk)
    disable iff (!nrst) $rose(sda_dev_oe) |-> !scl)
    else $error("device sda moved in scl high");
  ack_hold_a: assert property (@(posedge link_clk)
    disable iff (!nrst) $fell(sda_dev_oe) |-> !scl)
    else $error("device ack cut short");
  hold_start_a: assert property (@(posedge link_clk)
    disable iff (!nrst) $rose(scl_dev_oe) |-> !scl)
    else $error("device held scl from high");
  hold_end_a: assert property (@(posedge link_clk)
    disable iff (!nrst) $fell(scl_dev_oe) |-> scl [*3])
    else $error("scl not freed after hold");
  reset_free_a: assert property (@(posedge ref_clk)
    !nrst |-> !sda_dev_oe && !scl_dev_oe && !sda_host_oe && !scl_host_oe)
    else $error("bus driven in reset");
endmodule : aip_bus_properties
`default_nettype wire

// ===== verification/testbench.sv
// bench joining host end and device end on one bus
// assumes package, bus interface and both ends compiled first
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned VW[3] = '{31000, 32000, 33000};
  localparam int unsigned TW[3] = '{20000, 21000, 22000};
  logic       ref_clk, link_clk, nrst, pin, req_valid, req_read, req_sel;
  logic       req_ready, wr_take, rd_valid, done, nack, rx_valid, wait_busy;
  logic [1:0] fs_sel;
  logic [3:0] req_len;
  logic [7:0] wr_data, rd_data, rx_data, d0, d1;
  logic [8:0] sh;
  logic [7:0] wire_q[$], rx_q[$], pl[$];
  logic       ack_q[$];
  int         bitn, busy, max_low, bad_count, checks_done, n, f;
  int         lens[$];
  wire logic  scl_b;
  wire logic  sda_b;

  aip_bus_if aip_bus_if_i ();
  assign scl_b = aip_bus_if_i.scl;
  assign sda_b = aip_bus_if_i.sda;
  aip_dev_end #(.VOL_WAIT_32(VW[0]), .VOL_WAIT_44(VW[1]),
    .VOL_WAIT_48(VW[2]), .TONE_WAIT_32(TW[0]), .TONE_WAIT_44(TW[1]),
    .TONE_WAIT_48(TW[2])) aip_dev_end_i (.ref_clk(ref_clk),
    .link_clk(link_clk), .nrst(nrst), .addr_select_pin(pin),
    .fs_sel(fs_sel), .rx_data(rx_data), .rx_valid(rx_valid),
    .wait_busy(wait_busy), .bus(aip_bus_if_i));
  aip_host_end aip_host_end_i (.ref_clk(ref_clk), .nrst(nrst),
    .req_valid(req_valid), .req_read(req_read), .req_sel(req_sel),
    .req_len(req_len), .wr_data(wr_data), .req_ready(req_ready),
    .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid),
    .done(done), .nack(nack), .bus(aip_bus_if_i));
  aip_bus_properties aip_bus_properties_i (.ref_clk(ref_clk),
    .link_clk(link_clk), .nrst(nrst), .scl(scl_b), .sda(sda_b),
    .scl_dev_oe(aip_bus_if_i.scl_dev_oe),
    .sda_dev_oe(aip_bus_if_i.sda_dev_oe),
    .scl_host_oe(aip_bus_if_i.scl_host_oe),
    .sda_host_oe(aip_bus_if_i.sda_host_oe));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    link_clk = 1'b0;
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end

  // wire monitor: bytes and ack bits after each start
  always @(negedge sda_b) begin
    if (scl_b === 1'b1) bitn = 0;
  end
  always @(posedge scl_b) begin
    if (nrst === 1'b1) begin
      sh = {sh[7:0], sda_b};
      bitn++;
      if (bitn == 9) begin
        wire_q.push_back(sh[8:1]);
        ack_q.push_back(sh[0]);
        bitn = 0;
      end
    end
  end
  always @(negedge ref_clk) begin
    if (rx_valid === 1'b1) rx_q.push_back(rx_data);
    if (wait_busy === 1'b1) begin
      busy++;
    end else if (busy != 0) begin
      lens.push_back(busy);
      busy = 0;
    end
  end

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    checks_done++;
    if (exp !== got) begin
      $display("BAD %s expected %0h seen %0h", what, exp, got);
      bad_count++;
    end
  endtask : check

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  task automatic xfer(input logic rd, input logic sel, input logic mis);
    logic [7:0] got[$];
    int         i, low, cnt;
    logic       nk, tk;
    @(negedge ref_clk);
    wire_q.delete();
    ack_q.delete();
    rx_q.delete();
    nk = 1'b0;
    tk = 1'b0;
    i = 0;
    low = 0;
    max_low = 0;
    req_read = rd;
    req_sel = sel;
    req_len = 4'(pl.size());
    wr_data = pl[0];
    req_valid = 1'b1;
    for (n = 0; n < 80000 && done !== 1'b1; n++) begin
      @(negedge ref_clk);
      req_valid = 1'b0;
      // next byte only after the take pulse has passed
      if (tk) begin
        i++;
        wr_data = pl[i % pl.size()];
      end
      tk = wr_take === 1'b1;
      if (rd_valid === 1'b1) got.push_back(rd_data);
      if (nack === 1'b1) nk = 1'b1;
      low = scl_b === 1'b0 ? low + 1 : 0;
      max_low = low > max_low ? low : max_low;
    end
    if (done !== 1'b1) begin
      check("done", 1'b1, done);
      wrap_up();
    end
    cnt = mis ? 1 : pl.size() + 1;
    check("address", {6'h1A, sel, rd}, wire_q[0]);
    check("byte count", cnt, wire_q.size());
    check("refused", mis, nk);
    for (int k = 0; k < cnt; k++) begin
      check("ack bit", mis || (rd && k == cnt - 1), ack_q[k]);
    end
    for (int k = 0; k < cnt - 1; k++) begin
      check("wire byte", pl[k], wire_q[k + 1]);
      check("user byte", pl[k], rd ? got[k] : rx_q[k]);
    end
  endtask : xfer

  initial begin
    nrst = 1'b0;
    pin = 1'b0;
    req_valid = 1'b0;
    req_read = 1'b0;
    req_sel = 1'b0;
    req_len = 4'h0;
    wr_data = 8'h00;
    sh = 9'h000;
    bitn = 0;
    busy = 0;
    bad_count = 0;
    checks_done = 0;
    void'($urandom(66717));
    fs_sel = 2'($urandom_range(3));
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    repeat (10) @(negedge ref_clk);
    nrst = 1'b1;
    pl = {8'h04, d0};
    xfer(1'b0, 1'b0, 1'b0);
    for (n = 0; n < 100 && wait_busy !== 1'b1; n++) @(negedge ref_clk);
    check("wait running", 1'b1, wait_busy);
    if (wait_busy !== 1'b1) wrap_up();
    pl = {8'h06, d1};
    xfer(1'b0, 1'b0, 1'b0);
    check("scl held", 1'b1, max_low > 2000);
    pin = 1'b1;
    pl = {8'h00};
    xfer(1'b1, 1'b0, 1'b1);
    pl = {8'h04, d0, 8'h06};
    xfer(1'b1, 1'b1, 1'b0);
    for (n = 0; n < 30000 && lens.size() < 2; n++) @(negedge ref_clk);
    check("wait count", 2, lens.size());
    if (lens.size() < 2) wrap_up();
    f = fs_sel == 2'h3 ? 2 : int'(fs_sel);
    n = lens[0];
    check("volume wait", 1'b1, n + 4 >= VW[f] && n <= VW[f] + 4);
    n = lens[1];
    check("tone wait", 1'b1, n + 4 >= TW[f] && n <= TW[f] + 4);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
